/* qvd_map.svh */
// register map, reset values and timing counts of the quad valve driver control
// Behaviour
// - four channels run and report independently
// - per-channel 8-bit duty, 1/256 per step
// - duty ff always on, 00 always off
// - channels shifted by quarter period each
// - per-channel 10-bit target current
// - zero target disables the power stage
// - new target used by regulator at once
// - current sampled only during on phase
// - discrete PI regulator with programmed gains
// - shared integral gain resets to 1/32
// - regulators idle until integral gain programmed
// - regulated duty clamped between minimum and 100%
// - persistent regulation error sets error flag
// - regulation error only reports, never acts
// - regulation error flag cleared by its read
// - bypass flag: target msbs as duty
// - first duty set by first-duty control
// - switching slope selectable by command
// - open load checked off only, flag only
// - filtered drain voltage state bit
// - overcurrent switches off, status read, clear then target
`ifndef QVD_MAP_SVH
`define QVD_MAP_SVH
`define QVD_REG_CFG      5'h00
`define QVD_REG_GAIN     5'h01
`define QVD_REG_FCLR     5'h02
`define QVD_REG_TGT0     5'h04
`define QVD_REG_STAT0    5'h08
`define QVD_KI_RST       4'h2
`define QVD_KP_RST       4'h0
`define QVD_MIN_RST      8'h00
`define QVD_SLOPE_RST    2'h0
`define QVD_PHASE_STEP   8'h40
`define QVD_CLK_NS       5
`define QVD_PWM_NS       200000
`define QVD_PWM_TICK_CYC (`QVD_PWM_NS / (`QVD_CLK_NS * 256))
`define QVD_T_OL_NS      20000
`define QVD_T_VDS_NS     10000
`define QVD_T_OC_NS      10000
`define QVD_T_OT_NS      20000
`define QVD_OL_CYC       ((`QVD_T_OL_NS + `QVD_CLK_NS - 1) / `QVD_CLK_NS)
`define QVD_VDS_CYC      ((`QVD_T_VDS_NS + `QVD_CLK_NS - 1) / `QVD_CLK_NS)
`define QVD_OC_CYC       ((`QVD_T_OC_NS + `QVD_CLK_NS - 1) / `QVD_CLK_NS)
`define QVD_OT_CYC       ((`QVD_T_OT_NS + `QVD_CLK_NS - 1) / `QVD_CLK_NS)
`define QVD_CRERR_US     1000
`define QVD_CRERR_CYC    ((`QVD_CRERR_US * 1000 + `QVD_CLK_NS - 1) / `QVD_CLK_NS)
`define QVD_CRERR_THR    11'sh020
`define QVD_INT_MAX      22'sh003fc0
`endif

/* qvd_pkg.sv */
// types of the quad valve driver control
package qvd_pkg;
  typedef logic [7:0] qvd_duty_t;
  typedef logic [9:0] qvd_cur_t;
  typedef enum logic [1:0] {
    QVD_OFF = 2'b00,
    QVD_PWM = 2'b01,
    QVD_REG = 2'b10
  } qvd_mode_e;
endpackage

/* qvd_ctrl.sv */
// quad valve driver control: pwm, pi regulation, fault filtering, registers
`include "qvd_map.svh"
module qvd_ctrl #(
  parameter int unsigned CRERR_CYC = `QVD_CRERR_CYC
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic [4:0]       regAddr,
  input  wire logic [31:0]      regWdata,
  input  wire logic             regWr,
  input  wire logic             regRd,
  output logic [31:0]           regRdata,
  input  wire logic [3:0]       openLow,
  input  wire logic [3:0]       vdsHigh,
  input  wire logic [3:0]       ocDet,
  input  wire logic [3:0]       otDet,
  input  wire logic             adcValid,
  input  wire logic [1:0]       adcChan,
  input  wire qvd_pkg::qvd_cur_t adcCur,
  output logic [3:0]            gateOn,
  output logic [1:0]            slopeSel
);
  import qvd_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic qvd_duty_t clampDuty(input logic signed [21:0] v, input qvd_duty_t lo);
    logic signed [21:0] s;
    s = v >>> 6;
    if (s < $signed({14'h0000, lo})) clampDuty = lo;
    else if (s > 22'sh0000ff) clampDuty = 8'hff;
    else clampDuty = s[7:0];
  endfunction

  function automatic logic signed [21:0] satInt(input logic signed [21:0] v);
    if (v < 22'sh0) satInt = 22'sh0;
    else if (v > `QVD_INT_MAX) satInt = `QVD_INT_MAX;
    else satInt = v;
  endfunction

  // ----------------------------------------
  // registers and state
  // ----------------------------------------
  logic [1:0]         slope_reg;
  logic               firstFull_reg;
  qvd_duty_t          minDuty_reg;
  logic [3:0]         ki_reg;
  logic [3:0]         kp_reg;
  logic               kiSet_reg;
  qvd_cur_t           tgt_reg [4];
  qvd_cur_t           meas_reg [4];
  logic signed [21:0] integ_reg [4];
  logic [3:0]         byp_reg;
  logic [3:0]         onCmd_reg;
  logic [3:0]         first_reg;
  logic [3:0]         seen_reg;
  logic [3:0]         olF_reg;
  logic [3:0]         ocF_reg;
  logic [3:0]         otF_reg;
  logic [3:0]         crer_reg;
  logic [11:0]        flt_reg [4][4];
  logic [23:0]        crCnt_reg [4];
  logic [7:0]         div_reg;
  logic [7:0]         pwm_reg;
  logic [15:0]        s1_reg;
  logic [15:0]        s2_reg;
  logic [15:0]        s3_reg;
  logic [15:0]        pin_reg;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire       wrCfg  = regWr && regAddr == `QVD_REG_CFG;
  wire       wrGain = regWr && regAddr == `QVD_REG_GAIN;
  wire       wrClr  = regWr && regAddr == `QVD_REG_FCLR;
  wire       wrTgt  = regWr && {regAddr[4:2], 2'b00} == `QVD_REG_TGT0;
  wire       isStat = {regAddr[4:2], 2'b00} == `QVD_REG_STAT0;
  wire       rdStat = regRd && isStat;
  wire [1:0] selCh  = regAddr[1:0];
  wire       tick   = div_reg == 8'(`QVD_PWM_TICK_CYC - 1);
  wire       regRun = kiSet_reg;

  // ----------------------------------------
  // per-channel combinational path
  // ----------------------------------------
  qvd_mode_e          mode [4];
  qvd_duty_t          duty [4];
  qvd_duty_t          phCnt [4];
  logic signed [10:0] errM [4];
  logic [3:0]         pwmOn;
  logic [3:0]         perEnd;
  logic [3:0]         crBad;
  logic [3:0]         cond [4];
  logic [3:0]         hit [4];
  logic [3:0]         clrOk;
  logic [11:0]        lim [4];

  assign lim[0] = 12'(`QVD_OL_CYC);
  assign lim[1] = 12'(`QVD_VDS_CYC);
  assign lim[2] = 12'(`QVD_OC_CYC);
  assign lim[3] = 12'(`QVD_OT_CYC);

  always_comb begin
    for (int c = 0; c < 4; c++) begin
      phCnt[c] = 8'(pwm_reg + 8'(c) * `QVD_PHASE_STEP);
      perEnd[c] = tick && phCnt[c] == 8'hff;
      errM[c] = $signed({1'b0, tgt_reg[c]}) - $signed({1'b0, meas_reg[c]});
      if (tgt_reg[c] == 10'h000) mode[c] = QVD_OFF;
      else if (byp_reg[c]) mode[c] = QVD_PWM;
      else if (regRun) mode[c] = QVD_REG;
      else mode[c] = QVD_OFF;
      case (mode[c])
        QVD_PWM: duty[c] = tgt_reg[c][9:2];
        QVD_REG: duty[c] = clampDuty(integ_reg[c] + 22'(kp_reg) * 22'(errM[c]), minDuty_reg);
        default: duty[c] = 8'h00;
      endcase
      if (first_reg[c] && firstFull_reg && mode[c] != QVD_OFF) duty[c] = 8'hff;
      pwmOn[c] = duty[c] == 8'hff || phCnt[c] < duty[c];
      crBad[c] = mode[c] == QVD_REG && (errM[c] > `QVD_CRERR_THR || errM[c] < -`QVD_CRERR_THR);
      cond[c][0] = pin_reg[c] && !gateOn[c];
      cond[c][1] = pin_reg[4 + c];
      cond[c][2] = pin_reg[8 + c];
      cond[c][3] = pin_reg[12 + c];
      for (int k = 0; k < 4; k++) hit[c][k] = flt_reg[c][k] == lim[k];
      clrOk[c] = wrClr && regWdata[c] && seen_reg[c];
    end
  end

  // ----------------------------------------
  // input synchronisers, change counts once s2 and s3 agree
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s1_reg <= 16'h0000;
      s2_reg <= 16'h0000;
      s3_reg <= 16'h0000;
      pin_reg <= 16'h0000;
    end else begin
      s1_reg <= {otDet, ocDet, vdsHigh, openLow};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < 16; i++) if (s2_reg[i] == s3_reg[i]) pin_reg[i] <= s3_reg[i];
    end
  end

  // ----------------------------------------
  // pwm time base
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      div_reg <= 8'h00;
      pwm_reg <= 8'h00;
    end else begin
      div_reg <= tick ? 8'h00 : 8'(div_reg + 8'h01);
      if (tick) pwm_reg <= 8'(pwm_reg + 8'h01);
    end
  end

  // ----------------------------------------
  // shared configuration
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      slope_reg <= `QVD_SLOPE_RST;
      firstFull_reg <= 1'b0;
      minDuty_reg <= `QVD_MIN_RST;
      ki_reg <= `QVD_KI_RST;
      kp_reg <= `QVD_KP_RST;
      kiSet_reg <= 1'b0;
    end else begin
      if (wrCfg) begin
        slope_reg <= regWdata[1:0];
        firstFull_reg <= regWdata[2];
        minDuty_reg <= regWdata[11:4];
      end
      if (wrGain) begin
        ki_reg <= regWdata[3:0];
        kp_reg <= regWdata[7:4];
        kiSet_reg <= regWdata[3:0] != 4'h0;
      end
    end
  end

  // ----------------------------------------
  // channel commands and regulator, each channel alone
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      byp_reg <= 4'h0;
      onCmd_reg <= 4'h0;
      first_reg <= 4'h0;
      for (int c = 0; c < 4; c++) begin
        tgt_reg[c] <= 10'h000;
        meas_reg[c] <= 10'h000;
        integ_reg[c] <= 22'sh0;
      end
    end else begin
      for (int c = 0; c < 4; c++) begin
        if (perEnd[c]) first_reg[c] <= 1'b0;
        if (wrTgt && selCh == 2'(c)) begin
          tgt_reg[c] <= regWdata[9:0];
          byp_reg[c] <= regWdata[12];
          first_reg[c] <= 1'b1;
          onCmd_reg[c] <= regWdata[9:0] != 10'h000 && !ocF_reg[c] && !otF_reg[c];
        end
        // fault hit wins over a target write in the same cycle
        if (hit[c][2] || hit[c][3]) onCmd_reg[c] <= 1'b0;
        if (adcValid && adcChan == 2'(c) && gateOn[c]) begin
          meas_reg[c] <= adcCur;
          if (mode[c] == QVD_REG)
            integ_reg[c] <= satInt(integ_reg[c] + 22'(ki_reg) *
                                   22'($signed({1'b0, tgt_reg[c]}) - $signed({1'b0, adcCur})));
        end
        if (mode[c] != QVD_REG) integ_reg[c] <= 22'sh0;
      end
    end
  end

  // ----------------------------------------
  // fault filters and flags
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      olF_reg <= 4'h0;
      ocF_reg <= 4'h0;
      otF_reg <= 4'h0;
      crer_reg <= 4'h0;
      seen_reg <= 4'h0;
      for (int c = 0; c < 4; c++) begin
        crCnt_reg[c] <= 24'h000000;
        for (int k = 0; k < 4; k++) flt_reg[c][k] <= 12'h000;
      end
    end else begin
      for (int c = 0; c < 4; c++) begin
        for (int k = 0; k < 4; k++)
          flt_reg[c][k] <= !cond[c][k] ? 12'h000 : hit[c][k] ? flt_reg[c][k] : 12'(flt_reg[c][k] + 12'h001);
        if (rdStat && selCh == 2'(c)) seen_reg[c] <= 1'b1;
        if (clrOk[c]) begin
          seen_reg[c] <= 1'b0;
          olF_reg[c] <= 1'b0;
          ocF_reg[c] <= 1'b0;
          if (!pin_reg[12 + c]) otF_reg[c] <= 1'b0;
        end
        if (hit[c][0]) olF_reg[c] <= 1'b1;
        if (hit[c][2]) ocF_reg[c] <= 1'b1;
        if (hit[c][3]) otF_reg[c] <= 1'b1;
        crCnt_reg[c] <= !crBad[c] ? 24'h000000 :
                        crCnt_reg[c] == 24'(CRERR_CYC) ? crCnt_reg[c] : 24'(crCnt_reg[c] + 24'h000001);
        if (rdStat && selCh == 2'(c)) crer_reg[c] <= 1'b0;
        if (crCnt_reg[c] == 24'(CRERR_CYC) && crBad[c]) crer_reg[c] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // outputs and read data
  // ----------------------------------------
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h00000000;
    if (regAddr == `QVD_REG_CFG) rdMux = {20'h00000, minDuty_reg, 1'b0, firstFull_reg, slope_reg};
    else if (regAddr == `QVD_REG_GAIN) rdMux = {24'h000000, kp_reg, ki_reg};
    else if ({regAddr[4:2], 2'b00} == `QVD_REG_TGT0) rdMux = {19'h00000, byp_reg[selCh], 2'b00, tgt_reg[selCh]};
    else if (isStat)
      rdMux = {27'h0000000, crer_reg[selCh], otF_reg[selCh], ocF_reg[selCh], hit[selCh][1], olF_reg[selCh]};
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      regRdata <= 32'h00000000;
      gateOn <= 4'h0;
      slopeSel <= `QVD_SLOPE_RST;
    end else begin
      regRdata <= regRd ? rdMux : 32'h00000000;
      gateOn <= onCmd_reg & ~ocF_reg & ~otF_reg & pwmOn;
      slopeSel <= slope_reg;
    end
  end
endmodule // qvd_ctrl

/* qvd_ctrl_props.sv */
// concurrent checks on the ports of the quad valve driver control
`include "qvd_map.svh"
module qvd_ctrl_props #(
  parameter int unsigned CRERR_CYC = `QVD_CRERR_CYC
) (
  input wire logic              clk_sys,
  input wire logic              sys_rst,
  input wire logic [4:0]        regAddr,
  input wire logic [31:0]       regWdata,
  input wire logic              regWr,
  input wire logic              regRd,
  input wire logic [31:0]       regRdata,
  input wire logic [3:0]        openLow,
  input wire logic [3:0]        vdsHigh,
  input wire logic [3:0]        ocDet,
  input wire logic [3:0]        otDet,
  input wire logic              adcValid,
  input wire logic [1:0]        adcChan,
  input wire qvd_pkg::qvd_cur_t adcCur,
  input wire logic [3:0]        gateOn,
  input wire logic [1:0]        slopeSel
);
  timeunit 1ns;
  timeprecision 100ps;
  import qvd_pkg::*;
  // ----------------------------------------
  // shadow state of what the host asked for and of how long the oc and ot inputs are held
  // ----------------------------------------
  localparam int OcLim = `QVD_OC_CYC + 12;
  localparam int OtLim = `QVD_OT_CYC + 12;
  logic [12:0] ocCnt_reg;
  logic [12:0] otCnt_reg;
  logic [1:0]  slope_reg;
  logic        anyTgt_reg;
  logic        full_reg;
  wire         tgt0Wr = regWr && regAddr == `QVD_REG_TGT0;
  wire         cfgWr  = regWr && regAddr == `QVD_REG_CFG;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ocCnt_reg  <= 13'h0;
      otCnt_reg  <= 13'h0;
      slope_reg  <= 2'h0;
      anyTgt_reg <= 1'b0;
      full_reg   <= 1'b0;
    end else begin
      ocCnt_reg  <= ocDet[2] ? ocCnt_reg + {12'h0, ~&ocCnt_reg} : 13'h0;
      otCnt_reg  <= otDet[3] ? otCnt_reg + {12'h0, ~&otCnt_reg} : 13'h0;
      slope_reg  <= cfgWr ? regWdata[1:0] : slope_reg;
      anyTgt_reg <= anyTgt_reg | (regWr && regAddr[4:2] == 3'b001);
      full_reg   <= tgt0Wr ? (regWdata[12] && regWdata[9:2] == 8'hff) : full_reg;
    end
  end
  sequence zeroTgtWr;
    tgt0Wr && regWdata[9:0] == 10'h0;
  endsequence
  sequence fullHeld;
    full_reg [*3];
  endsequence
  rdIdle_a: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data outside answer");
  unmapRd_a: assert property ($past(regRd && regAddr == 5'h03) |-> regRdata == 32'h0)
    else $error("unmapped read not zero");
  slopeCopy_a: assert property (!$past(cfgWr) && !$past(cfgWr, 2) |-> slopeSel == slope_reg)
    else $error("slope select not copied");
  noTarget_a: assert property (!anyTgt_reg |-> gateOn == 4'h0)
    else $error("gate on without target");
  zeroOff_a: assert property (zeroTgtWr |-> ##3 !gateOn[0])
    else $error("zero target left gate on");
  fullOn_a: assert property (fullHeld |-> gateOn[0])
    else $error("full duty gate off");
  ocOff_a: assert property (ocCnt_reg >= OcLim |-> !gateOn[2])
    else $error("overcurrent left gate on");
  otOff_a: assert property (otCnt_reg >= OtLim |-> gateOn[3] == 1'b0)
    else $error("overtemp left gate on");
endmodule  // qvd_ctrl_props

bind qvd_ctrl qvd_ctrl_props #(.CRERR_CYC(CRERR_CYC)) i_props (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata), .openLow(openLow), .vdsHigh(vdsHigh), .ocDet(ocDet),
  .otDet(otDet), .adcValid(adcValid), .adcChan(adcChan), .adcCur(adcCur), .gateOn(gateOn),
  .slopeSel(slopeSel));

/* qvd_load_model.sv */
// solenoid loads, fault comparators and current sense of the four channels
module qvd_load_model (
  input wire logic              clk_sys,
  input wire logic [3:0]        gateOn,
  input wire logic [3:0]        ocForce,
  input wire logic [3:0]        otForce,
  input wire logic [3:0]        openForce,
  input wire qvd_pkg::qvd_cur_t loadCur,
  output logic [3:0]            openLow,
  output logic [3:0]            vdsHigh,
  output logic [3:0]            ocDet,
  output logic [3:0]            otDet,
  output logic                  adcValid,
  output logic [1:0]            adcChan,
  output qvd_pkg::qvd_cur_t     adcCur
);
  timeunit 1ns;
  timeprecision 100ps;
  import qvd_pkg::*;
  // ----------------------------------------
  // comparators and sense converter
  // ----------------------------------------
  logic [3:0] div_reg   = 4'h0;
  logic       valid_reg = 1'b0;
  logic [1:0] chan_reg  = 2'h0;
  wire  [1:0] nextChan  = chan_reg + 2'h1;
  assign openLow  = openForce & ~gateOn;
  assign vdsHigh  = ~gateOn;
  assign ocDet    = ocForce;
  assign otDet    = otForce;
  assign adcValid = valid_reg;
  assign adcChan  = chan_reg;
  // off-phase samples are garbage, judged in the sample's own cycle
  assign adcCur   = gateOn[chan_reg] ? loadCur : ~loadCur;
  always @(posedge clk_sys) begin
    div_reg   <= div_reg + 4'h1;
    valid_reg <= div_reg == 4'h0;
    if (div_reg == 4'h0) chan_reg <= nextChan;
  end
endmodule  // qvd_load_model

/* qvd_ctrl_test.sv */
// self-checking bench of the quad valve driver control
`include "qvd_map.svh"
module qvd_ctrl_test;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // bench signals, design and loads
  // ----------------------------------------
  localparam logic [4:0] TgtA = `QVD_REG_TGT0;
  localparam logic [4:0] StaA = `QVD_REG_STAT0;
  logic              clk_sys   = 1'b0;
  logic              sys_rst   = 1'b1;
  logic [4:0]        regAddr   = 5'h0;
  logic [31:0]       regWdata  = 32'h0;
  logic              regWr     = 1'b0;
  logic              regRd     = 1'b0;
  logic [3:0]        ocForce   = 4'h0;
  logic [3:0]        otForce   = 4'h0;
  logic [3:0]        openForce = 4'h0;
  qvd_pkg::qvd_cur_t loadCur   = 10'h0;
  qvd_pkg::qvd_cur_t adcCur;
  logic [31:0]       regRdata, rdv;
  logic [3:0]        openLow, vdsHigh, ocDet, otDet, gateOn;
  logic [1:0]        adcChan, slopeSel;
  logic              adcValid;
  int                fails     = 0;
  int                checked   = 0;
  always #2.5 clk_sys = ~clk_sys;
  qvd_ctrl #(.CRERR_CYC(50)) i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .openLow(openLow),
    .vdsHigh(vdsHigh), .ocDet(ocDet), .otDet(otDet), .adcValid(adcValid), .adcChan(adcChan),
    .adcCur(adcCur), .gateOn(gateOn), .slopeSel(slopeSel));
  qvd_load_model i_load (.clk_sys(clk_sys), .gateOn(gateOn), .ocForce(ocForce), .otForce(otForce),
    .openForce(openForce), .loadCur(loadCur), .openLow(openLow), .vdsHigh(vdsHigh), .ocDet(ocDet),
    .otDet(otDet), .adcValid(adcValid), .adcChan(adcChan), .adcCur(adcCur));
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk_sys);
    regWr    <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [4:0] a);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk_sys);
    regRd   <= 1'b0;
    @(posedge clk_sys);
    rdv = regRdata;
  endtask
  task automatic holdGate(input string nm, input int c, input logic v, input int n);
    logic seen;
    seen = v;
    repeat (n) begin
      @(posedge clk_sys);
      if (gateOn[c] !== v) seen = gateOn[c];
    end
    cmp(nm, {31'h0, v}, {31'h0, seen});
  endtask
  task automatic waitGate(input int c, input logic v);
    int k;
    k = 0;
    while (gateOn[c] !== v && k < 45000) begin
      @(posedge clk_sys);
      k++;
    end
    cmp("gate wait", {31'h0, v}, {31'h0, gateOn[c]});
  endtask
  task automatic close_out;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk_sys);
    fails++;
    $display("ERROR watchdog expected done seen hang");
    close_out();
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    rd(`QVD_REG_GAIN);
    cmp("gain reset", {24'h0, `QVD_KP_RST, `QVD_KI_RST}, rdv);
    rd(5'h03);
    cmp("unmapped", 32'h0, rdv);
    for (int s = 3; s >= 0; s--) begin
      wr(`QVD_REG_CFG, 32'(s));
      @(posedge clk_sys);
      cmp("slope", 32'(s), {30'h0, slopeSel});
    end
    wr(TgtA + 5'h1, 32'h100);
    holdGate("idle reg", 1, 1'b0, 1000);
    openForce <= 4'h3;
    wr(TgtA, 32'h13fc);
    wr(TgtA + 5'h1, 32'h1001);
    holdGate("duty ff", 0, 1'b1, 4200);
    holdGate("duty 00", 1, 1'b0, 100);
    rd(StaA);
    cmp("on status", 32'h0, rdv & 32'h3);
    rd(StaA + 5'h1);
    cmp("off status", 32'h3, rdv & 32'h3);
    wr(TgtA, 32'h0);
    holdGate("zero tgt", 0, 1'b0, 100);
    for (int c = 0; c < 4; c++) wr(TgtA + 5'(c), 32'h1200);
    waitGate(0, 1'b0);
    waitGate(0, 1'b1);
    repeat (32 * `QVD_PWM_TICK_CYC) @(posedge clk_sys);
    cmp("phase a", 32'h3, {28'h0, gateOn});
    repeat (64 * `QVD_PWM_TICK_CYC) @(posedge clk_sys);
    cmp("phase b", 32'h9, {28'h0, gateOn});
    ocForce <= 4'h4;
    repeat (2100) @(posedge clk_sys);
    ocForce <= 4'h0;
    rd(StaA + 5'h2);
    cmp("oc flag", 32'h4, rdv & 32'h4);
    wr(TgtA + 5'h2, 32'h13fc);
    holdGate("oc latched", 2, 1'b0, 200);
    wr(`QVD_REG_FCLR, 32'h4);
    wr(TgtA + 5'h2, 32'h13fc);
    holdGate("oc back", 2, 1'b1, 200);
    otForce <= 4'h8;
    repeat (4100) @(posedge clk_sys);
    rd(StaA + 5'h3);
    cmp("ot flag", 32'h8, rdv & 32'h8);
    wr(`QVD_REG_FCLR, 32'h8);
    rd(StaA + 5'h3);
    cmp("ot hot", 32'h8, rdv & 32'h8);
    otForce <= 4'h0;
    repeat (10) @(posedge clk_sys);
    wr(`QVD_REG_FCLR, 32'h8);
    wr(TgtA + 5'h3, 32'h13fc);
    holdGate("ot back", 3, 1'b1, 200);
    wr(`QVD_REG_CFG, 32'h404);
    wr(`QVD_REG_GAIN, 32'hf);
    wr(TgtA + 5'h1, 32'h100);
    holdGate("first duty", 1, 1'b1, 400);
    wr(`QVD_REG_CFG, 32'h400);
    repeat (5000) @(posedge clk_sys);
    rd(StaA + 5'h1);
    cmp("reg error", 32'h10, rdv & 32'h10);
    holdGate("reg full", 1, 1'b1, 500);
    loadCur <= 10'h100;
    repeat (300) @(posedge clk_sys);
    rd(StaA + 5'h1);
    cmp("err latched", 32'h10, rdv & 32'h10);
    rd(StaA + 5'h1);
    cmp("err cleared", 32'h0, rdv & 32'h10);
    loadCur <= 10'h3ff;
    waitGate(1, 1'b0);
    waitGate(1, 1'b1);
    holdGate("min duty on", 1, 1'b1, 60 * `QVD_PWM_TICK_CYC);
    repeat (8 * `QVD_PWM_TICK_CYC) @(posedge clk_sys);
    cmp("min duty off", 32'h0, {31'h0, gateOn[1]});
    close_out();
  end
endmodule  // qvd_ctrl_test
